// [rtl/pcic_cfg.svh]
/*
  Constants of the pulse counter with input conditioning: register offsets,
  reset values, function codes and timing figures.
  Assumes a 40 MHz clock and an APB slave with an 8-bit byte address.
*/
`ifndef PCIC_CFG_SVH
`define PCIC_CFG_SVH

// Clock and sizes
`define PCIC_CLK_NS        25
`define PCIC_NIN           10
`define PCIC_NOUT          5
`define PCIC_NPOL          5
`define PCIC_NDLY          3
`define PCIC_FN_W          6
`define PCIC_CNT_W         32
`define PCIC_FILT_W        16
`define PCIC_DLY_W         10
`define PCIC_ADDR_W        8

// Terminal function codes
`define PCIC_FN_COUNT_IN     6'h19
`define PCIC_FN_SET_REACHED  6'h08
`define PCIC_FN_DESIG_REACHED 6'h09
`define PCIC_FN_NONE         6'h00

// Default filter time, and its cycle count rounded up
`define PCIC_FILT_DEF_NS   10000
`define PCIC_FILT_DEF_CYC  ((`PCIC_FILT_DEF_NS + `PCIC_CLK_NS - 1) / `PCIC_CLK_NS)

// Register byte offsets
`define PCIC_OFF_LIMIT     8'h00
`define PCIC_OFF_DESIG     8'h04
`define PCIC_OFF_POL       8'h08
`define PCIC_OFF_POL_EXT   8'h0c
`define PCIC_OFF_FILT      8'h10
`define PCIC_OFF_DELAY     8'h14
`define PCIC_OFF_FUNC_LO   8'h18
`define PCIC_OFF_FUNC_HI   8'h1c
`define PCIC_OFF_OUT_FUNC  8'h20
`define PCIC_OFF_COUNT     8'h24
`define PCIC_OFF_STATUS    8'h28
`define PCIC_OFF_MASK      8'h2c
`define PCIC_OFF_INPUTS    8'h30

// Reset values
`define PCIC_LIMIT_RST     32'hffff_ffff
`define PCIC_DESIG_RST     32'hffff_ffff
`define PCIC_POL_RST       5'h00
`define PCIC_DLY_RST       30'h0000_0000
`define PCIC_FUNC_RST      60'h0
`define PCIC_OFUNC_RST     30'h0000_0000
`define PCIC_CNT_RST       32'h0000_0000
`define PCIC_STAT_RST      2'h0
`define PCIC_MASK_RST      2'h0

// Status bit positions
`define PCIC_ST_DESIG      0
`define PCIC_ST_SET        1

`endif

// [rtl/pcic_pkg.sv]
/*
  Types of the pulse counter with input conditioning: state records of the
  top module and of the per-terminal conditioner.
  Assumes pcic_cfg.svh is on the include path.
*/
package pcic_pkg;
`include "pcic_cfg.svh"

  // One input terminal's conditioning state
  typedef struct packed {
    logic [`PCIC_FILT_W-1:0] filt_cnt;
    logic                    filt_q;
    logic [`PCIC_DLY_W-1:0]  dly_cnt;
    logic                    dly_q;
  } pcic_cond_t;

  // Whole state of the counter block
  typedef struct packed {
    logic [`PCIC_CNT_W-1:0]             limit;
    logic [`PCIC_CNT_W-1:0]             desig;
    logic [`PCIC_NPOL-1:0]              pol;
    logic [`PCIC_NPOL-1:0]              pol_ext;
    logic [`PCIC_FILT_W-1:0]            filt;
    logic [`PCIC_NDLY*`PCIC_DLY_W-1:0]  dly;
    logic [`PCIC_NIN*`PCIC_FN_W-1:0]    func;
    logic [`PCIC_NOUT*`PCIC_FN_W-1:0]   ofunc;
    logic [`PCIC_CNT_W-1:0]             count;
    logic [1:0]                         status;
    logic [1:0]                         mask;
    logic [31:0]                        prdata;
    logic                               cnt_prev;
    logic [1:0]                         hit_prev;
    logic                               restored;
    logic [`PCIC_NOUT-1:0]              outs;
  } pcic_state_t;

endpackage : pcic_pkg

// [rtl/pcic_in_cond.sv]
/*
  One switch input terminal: polarity, noise filter and optional delay.
  Assumes the raw level is synchronous to clk and reads 1 when the terminal
  is shorted to its common return.
*/
`timescale 1ns/1ps
`include "pcic_cfg.svh"
module pcic_in_cond
  import pcic_pkg::*;
#(
  parameter bit HAS_DELAY = 1'b0
)
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    raw_in,
  input  wire logic                    invert,
  input  wire logic [`PCIC_FILT_W-1:0] filt_cycles,
  input  wire logic [`PCIC_DLY_W-1:0]  dly_cycles,
  output wire logic                    cond_out
);

  pcic_cond_t st_r;
  pcic_cond_t st_nxt;
  logic       lvl;

  // True once a differing level has lasted the programmed number of cycles
  function automatic logic pcic_settled(input logic [`PCIC_FILT_W-1:0] cnt,
                                        input logic [`PCIC_FILT_W-1:0] lim);
    pcic_settled = ((cnt + 16'h0001) >= lim);
  endfunction : pcic_settled

  // Polarity, filter, then delay
  always_comb
  begin
    st_nxt = st_r;
    lvl    = raw_in ^ invert; // R9 R10
    if (lvl == st_r.filt_q)
      st_nxt.filt_cnt = '0;
    else if (pcic_settled(st_r.filt_cnt, filt_cycles)) // R11
    begin
      st_nxt.filt_q   = lvl;
      st_nxt.filt_cnt = '0;
    end
    else
      st_nxt.filt_cnt = st_r.filt_cnt + 16'h0001;
    if (!HAS_DELAY)
    begin
      st_nxt.dly_q   = st_r.filt_q;
      st_nxt.dly_cnt = '0;
    end
    else if (st_r.filt_q == st_r.dly_q)
      st_nxt.dly_cnt = '0;
    else if (pcic_settled({6'h00, st_r.dly_cnt}, {6'h00, dly_cycles})) // R12
    begin
      st_nxt.dly_q   = st_r.filt_q;
      st_nxt.dly_cnt = '0;
    end
    else
      st_nxt.dly_cnt = st_r.dly_cnt + 10'h001;
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign cond_out = st_r.dly_q;

  // Filter output moves only to the corrected level after the full time
  filt_settle_a: assert property (@(posedge clk) disable iff (sys_rst) // R9 R10 R11
    (st_r.filt_q != $past(st_r.filt_q)) |->
      (($past(raw_in ^ invert) == st_r.filt_q) &&
       (($past(st_r.filt_cnt) + 16'h0001) >= $past(filt_cycles))))
    else $error("filter output changed early or to wrong level");

  // Delayed output follows filter only after the programmed delay
  dly_settle_a: assert property (@(posedge clk) disable iff (sys_rst) // R12
    (HAS_DELAY && (st_r.dly_q != $past(st_r.dly_q))) |->
      ((st_r.dly_q == $past(st_r.filt_q)) &&
       (($past(st_r.dly_cnt) + 10'h001) >= $past(dly_cycles))))
    else $error("delayed output changed early or to wrong level");

endmodule : pcic_in_cond

// [rtl/pcic_top.sv]
/*
  Pulse counter with input conditioning: ten switch inputs with polarity,
  filter, delay on the first three, function assignment, an event counter with designated
  and set thresholds driving output terminals, APB registers, interrupt.
  Assumes an APB master on clk and a retained store that keeps the count
  across power loss and returns it on retained_count_in after power-up.
*/
// Local design decisions: the address map and the APB interface to the registers.
// Contract
// (R1) Count pulses come only from inputs assigned function 25.
// (R2) Count equal to set limit turns on function-8 outputs and stops counting.
// (R3) Count reaching designated threshold turns on function-9 outputs; counting continues.
// (R4) Software never sets designated threshold above the set limit.
// (R5) Software puts functions 8 and 9 on different outputs.
// (R6) Counting goes on whether the drive runs or stands still.
// (R7) Count survives power loss; counting resumes from the stored value.
// (R8) High-rate pulses are wired to the fifth input terminal.
// (R9) Polarity bit 0: shorted input reads 1, open reads 0.
// (R10) Polarity bit 1 inverts that input among the first five.
// (R11) Every input passes a programmable filter before use.
// (R12) First three inputs also pass a programmable delay.
// (R13) Each of ten inputs takes its own function code out of 50.
// (R14) Counter adds one per inactive-to-active edge of the conditioned input.
`timescale 1ns/1ps
`include "pcic_cfg.svh"
module pcic_top
  import pcic_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`PCIC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output wire logic [31:0]             prdata,
  output wire logic                    pready,
  output wire logic                    pslverr,
  input  wire logic [`PCIC_NIN-1:0]    switch_input_terminal,
  input  wire logic [`PCIC_CNT_W-1:0]  retained_count_in,
  output wire logic [`PCIC_CNT_W-1:0]  retained_count_out,
  output wire logic [`PCIC_NOUT-1:0]   output_terminal,
  output wire logic                    irq
);

  pcic_state_t             r_r;
  pcic_state_t             r_nxt;
  logic [`PCIC_NIN-1:0]    cond;
  logic                    access;
  logic                    wr;
  logic                    cnt_wr;
  logic                    stat_rd;
  logic                    count_in;
  logic                    cnt_edge;
  logic                    set_hit;
  logic                    des_hit;
  logic [31:0]             rd_val;

  // Function code of terminal idx in a packed code vector
  function automatic logic [`PCIC_FN_W-1:0] pcic_fn_of(
    input logic [`PCIC_NIN*`PCIC_FN_W-1:0] codes,
    input int unsigned                     idx);
    pcic_fn_of = codes[idx*`PCIC_FN_W +: `PCIC_FN_W];
  endfunction : pcic_fn_of

  // Address hits a register word
  function automatic logic pcic_mapped(input logic [`PCIC_ADDR_W-1:0] a);
    pcic_mapped = (a[1:0] == 2'h0) && (a <= `PCIC_OFF_INPUTS);
  endfunction : pcic_mapped

  // Per-terminal conditioning; only the first three carry a delay
  for (genvar gi = 0; gi < `PCIC_NIN; gi++)
  begin : g_in
    logic                   inv;
    logic [`PCIC_DLY_W-1:0] dly;
    if (gi < `PCIC_NPOL)
    begin : g_pol
      assign inv = r_r.pol[gi]; // R10
    end
    else
    begin : g_pol_ext
      assign inv = r_r.pol_ext[gi-`PCIC_NPOL];
    end
    if (gi < `PCIC_NDLY)
    begin : g_dly
      assign dly = r_r.dly[gi*`PCIC_DLY_W +: `PCIC_DLY_W];
    end
    else
    begin : g_nodly
      assign dly = '0;
    end
    pcic_in_cond #(
      .HAS_DELAY (gi < `PCIC_NDLY)
    ) u_cond (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .raw_in      (switch_input_terminal[gi]),
      .invert      (inv),
      .filt_cycles (r_r.filt),
      .dly_cycles  (dly),
      .cond_out    (cond[gi])
    );
  end

  // Bus phase decode
  assign access  = psel & penable;
  assign wr      = access & pwrite & pcic_mapped(paddr);
  assign cnt_wr  = wr & (paddr == `PCIC_OFF_COUNT);
  assign stat_rd = access & ~pwrite & (paddr == `PCIC_OFF_STATUS);

  // Count source, edge and threshold hits
  always_comb
  begin
    count_in = 1'b0;
    for (int i = 0; i < `PCIC_NIN; i++)
    begin
      if (pcic_fn_of(r_r.func, i) == `PCIC_FN_COUNT_IN) // R1 R13
        count_in = count_in | cond[i];
    end
    cnt_edge = count_in & ~r_r.cnt_prev; // R14
    set_hit  = (r_r.count == r_r.limit);
    des_hit  = (r_r.count >= r_r.desig);
  end

  // Read data selection
  always_comb
  begin
    case (paddr)
      `PCIC_OFF_LIMIT:    rd_val = r_r.limit;
      `PCIC_OFF_DESIG:    rd_val = r_r.desig;
      `PCIC_OFF_POL:      rd_val = {27'h0, r_r.pol};
      `PCIC_OFF_POL_EXT:  rd_val = {27'h0, r_r.pol_ext};
      `PCIC_OFF_FILT:     rd_val = {16'h0, r_r.filt};
      `PCIC_OFF_DELAY:    rd_val = {2'h0, r_r.dly};
      `PCIC_OFF_FUNC_LO:  rd_val = {2'h0, r_r.func[29:0]};
      `PCIC_OFF_FUNC_HI:  rd_val = {2'h0, r_r.func[59:30]};
      `PCIC_OFF_OUT_FUNC: rd_val = {2'h0, r_r.ofunc};
      `PCIC_OFF_COUNT:    rd_val = r_r.count;
      `PCIC_OFF_STATUS:   rd_val = {30'h0, r_r.status};
      `PCIC_OFF_MASK:     rd_val = {30'h0, r_r.mask};
      `PCIC_OFF_INPUTS:   rd_val = {22'h0, cond};
      default:            rd_val = 32'h0000_0000;
    endcase
  end

  // Next state: counter, registers, outputs, events
  always_comb
  begin
    r_nxt          = r_r;
    r_nxt.cnt_prev = count_in;
    r_nxt.hit_prev = {set_hit, des_hit};
    // No run or stop input exists: counting never depends on drive state
    if (!r_r.restored) // R7
    begin
      r_nxt.count    = retained_count_in;
      r_nxt.restored = 1'b1;
    end
    else if (cnt_edge && !set_hit) // R2 R6 R14
      r_nxt.count = r_r.count + 32'h0000_0001;
    // Register writes at the access edge
    if (wr)
    begin
      case (paddr)
        `PCIC_OFF_LIMIT:    r_nxt.limit   = pwdata;
        `PCIC_OFF_DESIG:    r_nxt.desig   = pwdata;
        `PCIC_OFF_POL:      r_nxt.pol     = pwdata[4:0];
        `PCIC_OFF_POL_EXT:  r_nxt.pol_ext = pwdata[4:0];
        `PCIC_OFF_FILT:     r_nxt.filt    = pwdata[15:0];
        `PCIC_OFF_DELAY:    r_nxt.dly     = pwdata[29:0];
        `PCIC_OFF_FUNC_LO:  r_nxt.func[29:0]  = pwdata[29:0]; // R13
        `PCIC_OFF_FUNC_HI:  r_nxt.func[59:30] = pwdata[29:0];
        `PCIC_OFF_OUT_FUNC: r_nxt.ofunc   = pwdata[29:0];
        `PCIC_OFF_COUNT:    r_nxt.count   = pwdata;
        `PCIC_OFF_MASK:     r_nxt.mask    = pwdata[1:0];
        default:            r_nxt.limit   = r_r.limit;
      endcase
    end
    // Output terminals follow their assigned threshold
    for (int k = 0; k < `PCIC_NOUT; k++)
    begin
      r_nxt.outs[k] =
        ((pcic_fn_of({30'h0, r_r.ofunc}, k) == `PCIC_FN_SET_REACHED) && set_hit) || // R2
        ((pcic_fn_of({30'h0, r_r.ofunc}, k) == `PCIC_FN_DESIG_REACHED) && des_hit); // R3
    end
    // Read clears only the bits it returned; a new event wins
    if (stat_rd)
      r_nxt.status = r_r.status & ~r_r.prdata[1:0];
    r_nxt.status[`PCIC_ST_SET]   = r_nxt.status[`PCIC_ST_SET] | (set_hit & ~r_r.hit_prev[1]);
    r_nxt.status[`PCIC_ST_DESIG] = r_nxt.status[`PCIC_ST_DESIG] | (des_hit & ~r_r.hit_prev[0]);
    // Read data captured in the setup cycle
    if (psel && !penable && !pwrite)
      r_nxt.prdata = rd_val;
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      r_r          <= '0;
      r_r.limit    <= `PCIC_LIMIT_RST;
      r_r.desig    <= `PCIC_DESIG_RST;
      r_r.pol      <= `PCIC_POL_RST;
      r_r.pol_ext  <= `PCIC_POL_RST;
      r_r.filt     <= 16'(`PCIC_FILT_DEF_CYC);
      r_r.dly      <= `PCIC_DLY_RST;
      r_r.func     <= `PCIC_FUNC_RST;
      r_r.ofunc    <= `PCIC_OFUNC_RST;
      r_r.count    <= `PCIC_CNT_RST;
      r_r.status   <= `PCIC_STAT_RST;
      r_r.mask     <= `PCIC_MASK_RST;
    end
    else
      r_r <= r_nxt;
  end

  // Outputs
  assign prdata             = r_r.prdata;
  assign pready             = 1'b1;
  assign pslverr            = access & ~pcic_mapped(paddr);
  assign retained_count_out = r_r.count;
  assign output_terminal    = r_r.outs;
  assign irq                = |(r_r.status & r_r.mask);

  // Counter moves by at most one unless software writes it
  count_step_a: assert property (@(posedge clk) disable iff (sys_rst) // R14
    (r_r.restored && !cnt_wr) |=>
      ((r_r.count == $past(r_r.count)) || (r_r.count == $past(r_r.count) + 32'h1)))
    else $error("counter jumped by more than one");

  // An accepted edge below the limit adds exactly one
  count_inc_a: assert property (@(posedge clk) disable iff (sys_rst) // R6 R14
    (r_r.restored && !cnt_wr && cnt_edge && !set_hit) |=>
      (r_r.count == $past(r_r.count) + 32'h1))
    else $error("counter missed an edge");

  // Without an edge on a count-assigned input the count holds
  count_src_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
    (r_r.restored && !cnt_wr && !cnt_edge) |=> $stable(r_r.count))
    else $error("counter moved without a count input edge");

  // At the set limit the counter stands
  limit_halt_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
    (r_r.restored && !cnt_wr && set_hit) ##1 (!cnt_wr && set_hit) |=>
      (r_r.count == $past(r_r.count, 2)))
    else $error("counter ran past the set limit");

  // Retained count is loaded on the first cycle after reset
  restore_a: assert property (@(posedge clk) disable iff (sys_rst) // R7
    $rose(r_r.restored) |-> (r_r.count == $past(retained_count_in)))
    else $error("retained count not restored");

  // Reaching the set limit raises the sticky event
  stat_set_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
    (set_hit && !r_r.hit_prev[1]) |=> r_r.status[`PCIC_ST_SET])
    else $error("set-limit event not recorded");

  // Crossing the designated threshold raises the sticky event
  stat_desig_a: assert property (@(posedge clk) disable iff (sys_rst) // R3
    (des_hit && !r_r.hit_prev[0]) |=> r_r.status[`PCIC_ST_DESIG])
    else $error("designated event not recorded");

  // A status read clears the set event it returned unless it recurs
  stat_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    (stat_rd && r_r.prdata[`PCIC_ST_SET] && !(set_hit && !r_r.hit_prev[1])) |=>
      !r_r.status[`PCIC_ST_SET])
    else $error("status read did not clear the set-limit event");

  // A write to the set limit lands at the access edge
  limit_write_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
    (wr && (paddr == `PCIC_OFF_LIMIT)) |=> (r_r.limit == $past(pwdata)))
    else $error("set-limit write lost");

  // Output terminals follow their assigned thresholds
  for (genvar ka = 0; ka < `PCIC_NOUT; ka++)
  begin : g_out_chk
    out_set_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
      ((r_r.ofunc[ka*`PCIC_FN_W +: `PCIC_FN_W] == `PCIC_FN_SET_REACHED) && set_hit) |=>
        output_terminal[ka])
      else $error("set-limit output not on");
    out_desig_a: assert property (@(posedge clk) disable iff (sys_rst) // R3
      ((r_r.ofunc[ka*`PCIC_FN_W +: `PCIC_FN_W] == `PCIC_FN_DESIG_REACHED) && des_hit) |=>
        output_terminal[ka])
      else $error("designated output not on");
    out_set_off_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
      ((r_r.ofunc[ka*`PCIC_FN_W +: `PCIC_FN_W] == `PCIC_FN_SET_REACHED) && !set_hit) |=>
        !output_terminal[ka])
      else $error("set-limit output on away from the limit");
    out_desig_off_a: assert property (@(posedge clk) disable iff (sys_rst) // R3
      ((r_r.ofunc[ka*`PCIC_FN_W +: `PCIC_FN_W] == `PCIC_FN_DESIG_REACHED) && !des_hit) |=>
        !output_terminal[ka])
      else $error("designated output on below the threshold");
  end

  // Main scenarios
  limit_reach_c: cover property (@(posedge clk) disable iff (sys_rst)
    (r_r.restored && cnt_edge && (r_r.count + 32'h1 == r_r.limit)) ##1 set_hit);
  desig_pass_c: cover property (@(posedge clk) disable iff (sys_rst)
    (des_hit && !set_hit && cnt_edge) ##1 (des_hit && !set_hit));
  stat_clear_c: cover property (@(posedge clk) disable iff (sys_rst)
    (stat_rd && (r_r.prdata[1:0] != 2'h0)));
  restore_c: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(r_r.restored) && (r_r.count != 32'h0));

endmodule : pcic_top

// [dv/pcic_pulse_src.sv]
/*
  Model of the field side of the switch inputs: contacts and a pulse source.
  Assumes a level of 1 means the terminal is shorted to its common return,
  and that every change is made just after a rising edge of clk.
*/
`timescale 1ns/1ps
`include "pcic_cfg.svh"
module pcic_pulse_src
  import pcic_pkg::*;
(
  input  wire logic                 clk,
  output logic [`PCIC_NIN-1:0]      switch_input_terminal
);
  // All contacts open at power-up
  initial
  begin
    switch_input_terminal = '0;
  end

  // One closed-then-open pulse on one terminal
  task automatic pulse(input int idx, input int hi, input int lo);
    @(posedge clk);
    switch_input_terminal[idx] <= 1'b1;
    repeat (hi) @(posedge clk);
    switch_input_terminal[idx] <= 1'b0;
    repeat (lo) @(posedge clk);
  endtask : pulse

  // Contact held at a fixed level
  task automatic set_level(input int idx, input logic v);
    @(posedge clk);
    switch_input_terminal[idx] <= v;
  endtask : set_level
endmodule : pcic_pulse_src

// [dv/tb_top.sv]
/*
  Self-checking bench of the pulse counter: APB tasks, counting, thresholds,
  interrupt, polarity, filter, delay and count retention.
  Assumes pcic_cfg.svh on the include path and the pulse source model.
*/
`timescale 1ns/1ps
`include "pcic_cfg.svh"
module tb_top
  import pcic_pkg::*;
;
  logic                      clk;
  logic                      sys_rst;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [`PCIC_ADDR_W-1:0]   paddr;
  logic [31:0]               pwdata;
  wire logic [31:0]          prdata;
  wire logic                 pready;
  wire logic                 pslverr;
  wire logic [`PCIC_NIN-1:0] sw;
  logic [`PCIC_CNT_W-1:0]    ret_in;
  wire logic [`PCIC_CNT_W-1:0] ret_out;
  wire logic [`PCIC_NOUT-1:0] outs;
  wire logic                 irq;
  logic [31:0]               rd;
  logic                      err_bit;
  int                        errors;
  int                        samples_checked;

  pcic_top u_pcic_top (
    .clk                   (clk),
    .sys_rst               (sys_rst),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .switch_input_terminal (sw),
    .retained_count_in     (ret_in),
    .retained_count_out    (ret_out),
    .output_terminal       (outs),
    .irq                   (irq)
  );

  pcic_pulse_src u_pcic_pulse_src (
    .clk                   (clk),
    .switch_input_terminal (sw)
  );

  // Clock, 25 ns period
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // One APB transfer, held until pready is seen high
  task automatic apb_xfer(input logic wr, input logic [`PCIC_ADDR_W-1:0] a,
                          input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask : check_bit

  task automatic wr(input logic [`PCIC_ADDR_W-1:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d, rd, err_bit);
  endtask : wr

  task automatic rd_chk(input logic [`PCIC_ADDR_W-1:0] a, input logic [31:0] exp);
    apb_xfer(1'b0, a, 32'h0, rd, err_bit);
    check_word(rd, exp);
  endtask : rd_chk

  // Let n edges pass, then sample settled outputs
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic finish_test;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    errors          = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    ret_in  = 32'h0000_0005;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values, stored count picked up
    rd_chk(`PCIC_OFF_LIMIT, `PCIC_LIMIT_RST);
    rd_chk(`PCIC_OFF_DESIG, `PCIC_DESIG_RST);
    rd_chk(`PCIC_OFF_FILT, 32'h0000_0190);
    rd_chk(`PCIC_OFF_STATUS, 32'h0000_0000);
    rd_chk(`PCIC_OFF_COUNT, 32'h0000_0005);
    check_word(ret_out, 32'h0000_0005);
    // Unmapped place refused
    apb_xfer(1'b0, 8'h34, 32'h0, rd, err_bit);
    check_bit(err_bit, 1'b1);
    check_word(rd, 32'h0000_0000);
    // Thresholds and terminal functions
    wr(`PCIC_OFF_FILT, 32'h0000_0001);
    wr(`PCIC_OFF_COUNT, 32'h0000_0000);
    wr(`PCIC_OFF_DESIG, 32'h0000_0003);
    wr(`PCIC_OFF_LIMIT, 32'h0000_0005);
    wr(`PCIC_OFF_FUNC_LO, {2'h0, `PCIC_FN_COUNT_IN, 24'h0});
    wr(`PCIC_OFF_OUT_FUNC, {20'h0, `PCIC_FN_DESIG_REACHED, `PCIC_FN_SET_REACHED});
    wr(`PCIC_OFF_MASK, 32'h0000_0002);
    // Pulses on a terminal without the count function, then three on the count input
    repeat (2) u_pcic_pulse_src.pulse(1, 4, 4);
    rd_chk(`PCIC_OFF_COUNT, 32'h0000_0000);
    repeat (3) u_pcic_pulse_src.pulse(4, 4, 4);
    settle(6);
    rd_chk(`PCIC_OFF_COUNT, 32'h0000_0003);
    check_word({27'h0, outs}, 32'h0000_0002);
    check_bit(irq, 1'b0);
    wr(`PCIC_OFF_MASK, 32'h0000_0003);
    settle(1);
    check_bit(irq, 1'b1);
    rd_chk(`PCIC_OFF_STATUS, 32'h0000_0001);
    settle(1);
    check_bit(irq, 1'b0);
    rd_chk(`PCIC_OFF_STATUS, 32'h0000_0000);
    // Up to the set limit, then no further counting
    repeat (2) u_pcic_pulse_src.pulse(4, 4, 4);
    settle(6);
    rd_chk(`PCIC_OFF_COUNT, 32'h0000_0005);
    check_word({27'h0, outs}, 32'h0000_0003);
    check_bit(irq, 1'b1);
    rd_chk(`PCIC_OFF_STATUS, 32'h0000_0002);
    repeat (2) u_pcic_pulse_src.pulse(4, 4, 4);
    settle(6);
    rd_chk(`PCIC_OFF_COUNT, 32'h0000_0005);
    // Power cycle resumes from the stored value
    @(posedge clk);
    sys_rst <= 1'b1;
    ret_in  <= 32'h0000_0007;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(`PCIC_OFF_COUNT, 32'h0000_0007);
    // Polarity of terminals 4 and 5
    wr(`PCIC_OFF_FILT, 32'h0000_0001);
    u_pcic_pulse_src.set_level(4, 1'b1);
    settle(6);
    rd_chk(`PCIC_OFF_INPUTS, 32'h0000_0010);
    wr(`PCIC_OFF_POL, 32'h0000_0010);
    wr(`PCIC_OFF_POL_EXT, 32'h0000_0001);
    settle(6);
    rd_chk(`PCIC_OFF_INPUTS, 32'h0000_0020);
    u_pcic_pulse_src.set_level(4, 1'b0);
    wr(`PCIC_OFF_POL, 32'h0000_0000);
    wr(`PCIC_OFF_POL_EXT, 32'h0000_0000);
    // Filter drops short pulses on terminal 9
    wr(`PCIC_OFF_FILT, 32'h0000_0014);
    wr(`PCIC_OFF_FUNC_HI, {2'h0, `PCIC_FN_COUNT_IN, 24'h0});
    wr(`PCIC_OFF_COUNT, 32'h0000_0000);
    u_pcic_pulse_src.pulse(9, 5, 30);
    rd_chk(`PCIC_OFF_COUNT, 32'h0000_0000);
    u_pcic_pulse_src.pulse(9, 30, 30);
    rd_chk(`PCIC_OFF_COUNT, 32'h0000_0001);
    // Delay on terminal 0
    wr(`PCIC_OFF_FILT, 32'h0000_0001);
    wr(`PCIC_OFF_DELAY, 32'h0000_000a);
    wr(`PCIC_OFF_FUNC_LO, {26'h0, `PCIC_FN_COUNT_IN});
    u_pcic_pulse_src.set_level(0, 1'b1);
    rd_chk(`PCIC_OFF_INPUTS, 32'h0000_0000);
    settle(20);
    rd_chk(`PCIC_OFF_INPUTS, 32'h0000_0001);
    rd_chk(`PCIC_OFF_COUNT, 32'h0000_0002);
    finish_test();
  end
endmodule : tb_top
